// ### hw/rspm_manager.sv
`include "rspm_params.svh"

// =====================================================
// reset source priority manager
// Overview of operation
// - rank backup, wake-up, user, watchdog, software; higher rank wins, but the pin cannot pre-empt software or watchdog reset
// - in user reset the watchdog is held reset, so its request is ignored
// - in user reset no software reset request can be taken
// - in software reset a watchdog request pre-empts into watchdog reset
// - in software reset the external reset pin has no effect
// - in watchdog reset the processor reset output stays asserted
// - in watchdog reset software reset requests are not accepted
// - in watchdog reset the external pin cannot enter user reset
module rspm_manager
  import rspm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // reset requests
  input wire logic backup_req,
  input wire logic wakeup_req,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_req,
  input wire logic software_req,
  // processor reset and state
  output logic proc_reset_n,
  output logic [2:0] reset_state
);
  rspm_state_t state_reg;
  rspm_state_t state_next;
  logic [`RSPM_HOLD_W-1:0] hold_reg;
  logic pin_n_sync;
  // bit 0 backup, bit 1 wake-up, both after two flops
  logic [1:0] back_raw;
  logic [1:0] back_sync;
  logic user_req;

  // pins and other domains pass two flops before use
  // the pin idles high, so its synchroniser shows high until it has filled
  rspm_sync u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(external_reset_pin_n),
    .rst_val(1'b1),
    .sync_out(pin_n_sync)
  );

  // backup and wake-up come from the always-on side, also synchronised;
  // both idle low, so their synchronisers show low until filled
  assign back_raw = {wakeup_req, backup_req};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_back_sync
      rspm_sync u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(back_raw[gi]),
        .rst_val(1'b0),
        .sync_out(back_sync[gi])
      );
    end
  endgenerate

  assign user_req = ~pin_n_sync;

  // rank of a state; lower number is stronger
  function automatic logic [2:0] rank(input rspm_state_t s);
    unique case (s)
      RSPM_BACKUP: rank = 3'h1;
      RSPM_WAKEUP: rank = 3'h2;
      RSPM_USER: rank = 3'h3;
      RSPM_WATCHDOG: rank = 3'h4;
      RSPM_SOFTWARE: rank = 3'h5;
      RSPM_RUN: rank = 3'h7;
      default: rank = 3'h7;
    endcase
  endfunction

  // next state: strongest request that the current state lets in
  // the branches are ordered by rank, so a weaker source can never mask a
  // stronger one; the processor-side sources are gated by proc_reset_n, save a
  // watchdog request in software reset, because a core or watchdog held in reset
  // cannot raise them, and a stale level from before the hold must not slip in afterwards
  always_comb begin
    state_next = state_reg;
    if (back_sync[0]) begin
      state_next = RSPM_BACKUP;
    end else if (back_sync[1] && rank(state_reg) > 3'h2) begin
      state_next = RSPM_WAKEUP;
    end else if (user_req && rank(state_reg) > 3'h3 &&
                 state_reg != RSPM_SOFTWARE && state_reg != RSPM_WATCHDOG) begin
      // pin ignored in software and watchdog reset
      state_next = RSPM_USER;
    end else if (watchdog_req && proc_reset_n && rank(state_reg) > 3'h4) begin
      // watchdog is itself in reset while the processor is held, save in software reset
      state_next = RSPM_WATCHDOG;
    end else if (software_req && proc_reset_n && state_reg == RSPM_RUN) begin
      state_next = RSPM_SOFTWARE;
    end else if (state_reg == RSPM_SOFTWARE && watchdog_req) begin
      state_next = RSPM_WATCHDOG;
    end else if (state_reg != RSPM_RUN && hold_reg == '0 &&
                 !(state_reg == RSPM_USER && user_req)) begin
      state_next = RSPM_RUN;
    end
  end

  // state register
  // reset lands in running; the output flop keeps the processor held meanwhile
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg <= RSPM_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // hold counter restarts on every entry into a reset state
  // a pre-empting source restarts the full hold, trading a longer reset
  // for a guaranteed minimum width of every processor reset pulse
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hold_reg <= '0;
    end else if (state_next != state_reg && state_next != RSPM_RUN) begin
      hold_reg <= `RSPM_HOLD_CYCLES;
    end else if (hold_reg != '0) begin
      hold_reg <= hold_reg - 1'b1;
    end
  end

  // outputs straight from flops; reset asserts processor reset
  // driven from state_next so they move on the same edge as state_reg
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      proc_reset_n <= 1'b0;
      reset_state <= 3'h0;
    end else begin
      proc_reset_n <= (state_next == RSPM_RUN);
      reset_state <= state_next;
    end
  end

  // =====================================================
  // assertions
  sequence s_wd_entry;
    state_reg == RSPM_SOFTWARE ##0 watchdog_req && !back_sync[0] && !back_sync[1];
  endsequence

  a_wd_preempt: assert property (@(posedge ref_clk) disable iff (reset)
    s_wd_entry |=> state_reg == RSPM_WATCHDOG)
    else $error("watchdog did not pre-empt software reset");
  a_wd_holds_rst: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_WATCHDOG |-> !proc_reset_n)
    else $error("processor reset released in watchdog reset");
  a_sw_pin_ign: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_SOFTWARE |=> state_reg != RSPM_USER)
    else $error("pin changed software reset state");
  a_wd_no_user: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_WATCHDOG |=> state_reg != RSPM_USER)
    else $error("user reset entered from watchdog reset");
  a_wd_no_sw: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_WATCHDOG |=> state_reg != RSPM_SOFTWARE)
    else $error("software reset taken in watchdog reset");
  a_user_no_wd: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_USER |=> state_reg != RSPM_WATCHDOG)
    else $error("watchdog reset from user reset");
  a_user_no_sw: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_USER |=> state_reg != RSPM_SOFTWARE)
    else $error("software reset from user reset");
  a_backup_wins: assert property (@(posedge ref_clk) disable iff (reset)
    back_sync[0] |=> state_reg == RSPM_BACKUP)
    else $error("backup reset did not win");
  a_release_run: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg == RSPM_RUN && $past(state_reg) != RSPM_RUN |-> $past(hold_reg) == '0)
    else $error("released before hold ended");

  // =====================================================
  // entry checks; each antecedent names every stronger source as absent
  // so a legal pre-emption by a higher rank does not trip them
  sequence s_wake_entry;
    back_sync[1] && !back_sync[0] && state_reg != RSPM_BACKUP && state_reg != RSPM_WAKEUP;
  endsequence

  sequence s_user_entry;
    user_req && back_sync == 2'h0 && state_reg == RSPM_RUN;
  endsequence

  sequence s_sw_entry;
    state_reg == RSPM_RUN && proc_reset_n && software_req && !watchdog_req &&
    !user_req && back_sync == 2'h0;
  endsequence

  sequence s_wd_run_entry;
    state_reg == RSPM_RUN && proc_reset_n && watchdog_req && !user_req && back_sync == 2'h0;
  endsequence

  // wake-up pre-empts every weaker state
  a_wake_preempt: assert property (@(posedge ref_clk) disable iff (reset)
    s_wake_entry |=> state_reg == RSPM_WAKEUP)
    else $error("wake-up did not pre-empt a weaker state");
  // pin low while running enters user reset
  a_user_entry: assert property (@(posedge ref_clk) disable iff (reset)
    s_user_entry |=> state_reg == RSPM_USER)
    else $error("user reset not entered from running");
  // software is the weakest source but is still taken when alone
  a_sw_entry: assert property (@(posedge ref_clk) disable iff (reset)
    s_sw_entry |=> state_reg == RSPM_SOFTWARE)
    else $error("software reset not taken from running");
  // watchdog from running wins over a software request
  a_wd_run_entry: assert property (@(posedge ref_clk) disable iff (reset)
    s_wd_run_entry |=> state_reg == RSPM_WATCHDOG)
    else $error("watchdog reset not taken from running");
  // no reset state returns to running while its hold still runs
  a_no_early_run: assert property (@(posedge ref_clk) disable iff (reset)
    state_reg != RSPM_RUN && hold_reg != '0 |=> state_reg != RSPM_RUN)
    else $error("reset state left before its hold ended");
  // any reported reset state keeps the processor held
  a_out_held: assert property (@(posedge ref_clk) disable iff (reset)
    reset_state != 3'h0 |-> !proc_reset_n)
    else $error("processor reset released in a reset state");
endmodule

// ### hw/rspm_params.svh
`ifndef RSPM_PARAMS_SVH
`define RSPM_PARAMS_SVH
// =====================================================
// reset state manager constants
// hold count loaded on entry to a reset state; the processor reset is held one cycle more
`define RSPM_HOLD_CYCLES 8'h10
// width of the hold counter
`define RSPM_HOLD_W 8
`endif

// ### hw/rspm_pkg.sv
package rspm_pkg;
  // reset states, listed from highest to lowest rank after normal running
  typedef enum logic [2:0] {
    RSPM_RUN,
    RSPM_BACKUP,
    RSPM_WAKEUP,
    RSPM_USER,
    RSPM_WATCHDOG,
    RSPM_SOFTWARE
  } rspm_state_t;
endpackage

// ### hw/rspm_sync.sv
// =====================================================
// two flip-flop synchroniser for pin inputs
module rspm_sync
  import rspm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // level in and out
  input wire logic async_in,
  input wire logic rst_val,
  output logic sync_out
);
  logic meta_reg;
  logic sync_reg;
  logic [1:0] fill_reg;

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  // counts the two edges the stages need to fill after reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fill_reg <= 2'h0;
    end else if (fill_reg != 2'h2) begin
      fill_reg <= fill_reg + 2'h1;
    end
  end

  // show the idle level until the stages hold a real sample, so no false request follows reset
  assign sync_out = (fill_reg == 2'h2) ? sync_reg : rst_val;
endmodule

// ### verif/rspm_far_model.sv
// =====================================================
// watchdog timer and processor seen from the manager
module rspm_far_model (
  // bench commands
  input wire logic sw_cmd,
  input wire logic wd_cmd,
  // requests to the manager
  output logic software_req,
  output logic watchdog_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // passed through ungated so the bench can try a request while the
  // processor is held; a real core could not, which is the case to refuse
  assign software_req = sw_cmd;
  assign watchdog_req = wd_cmd;
endmodule

// ### verif/tb_rspm_manager.sv
// =====================================================
// bench for the reset source priority manager
module tb_rspm_manager;
  import rspm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic backup_req = 1'b0;
  logic wakeup_req = 1'b0;
  logic pin_n = 1'b1;
  logic sw_cmd = 1'b0;
  logic wd_cmd = 1'b0;
  logic watchdog_req, software_req, proc_reset_n;
  logic [2:0] reset_state;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // 50 ns period
  initial forever #25 ref_clk = ~ref_clk;
  // hang guard, far above the roughly 180 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end
  rspm_far_model rspm_far_model_i (.sw_cmd(sw_cmd), .wd_cmd(wd_cmd),
    .software_req(software_req), .watchdog_req(watchdog_req));
  rspm_manager rspm_manager_i (.ref_clk(ref_clk), .reset(reset), .backup_req(backup_req),
    .wakeup_req(wakeup_req), .external_reset_pin_n(pin_n), .watchdog_req(watchdog_req),
    .software_req(software_req), .proc_reset_n(proc_reset_n), .reset_state(reset_state));
  // =====================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // processor reset is released only in the running state
  task automatic chk(input rspm_state_t st);
    checks_done++;
    if (reset_state !== st || proc_reset_n !== (st == RSPM_RUN)) begin
      fail_count++;
      $display("Error t=%0t state %0h exp %0h rst_n %0h exp %0h", $time, reset_state, st,
               proc_reset_n, (st == RSPM_RUN));
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // =====================================================
  // scenarios
  task automatic s_soft_pin;
    @(posedge ref_clk) sw_cmd <= 1'b1;
    tick(1); chk(RSPM_SOFTWARE);
    @(posedge ref_clk) begin sw_cmd <= 1'b0; pin_n <= 1'b0; end
    tick(4); chk(RSPM_SOFTWARE);
    @(posedge ref_clk) wd_cmd <= 1'b1;
    tick(1); chk(RSPM_WATCHDOG);
  endtask
  task automatic s_wd_hold;
    @(posedge ref_clk) begin wd_cmd <= 1'b0; sw_cmd <= 1'b1; end
    tick(3); chk(RSPM_WATCHDOG);
    @(posedge ref_clk) begin sw_cmd <= 1'b0; pin_n <= 1'b1; end
    tick(25); chk(RSPM_RUN);
  endtask
  task automatic s_user;
    @(posedge ref_clk) pin_n <= 1'b0;
    tick(3); chk(RSPM_USER);
    @(posedge ref_clk) begin wd_cmd <= 1'b1; sw_cmd <= 1'b1; end
    tick(2); chk(RSPM_USER);
    @(posedge ref_clk) begin wd_cmd <= 1'b0; sw_cmd <= 1'b0; pin_n <= 1'b1; end
    tick(25); chk(RSPM_RUN);
  endtask
  task automatic s_rank;
    @(posedge ref_clk) pin_n <= 1'b0;
    tick(4); chk(RSPM_USER);
    @(posedge ref_clk) backup_req <= 1'b1;
    tick(3); chk(RSPM_BACKUP);
    @(posedge ref_clk) wakeup_req <= 1'b1;
    tick(4); chk(RSPM_BACKUP);
    @(posedge ref_clk) begin backup_req <= 1'b0; wakeup_req <= 1'b0; pin_n <= 1'b1; end
    tick(40); chk(RSPM_RUN);
  endtask
  task automatic s_wake_wd;
    @(posedge ref_clk) wd_cmd <= 1'b1;
    tick(1); chk(RSPM_WATCHDOG);
    @(posedge ref_clk) begin wd_cmd <= 1'b0; wakeup_req <= 1'b1; end
    tick(3); chk(RSPM_WAKEUP);
    @(posedge ref_clk) wakeup_req <= 1'b0;
    tick(25); chk(RSPM_RUN);
  endtask
  task automatic s_mid_reset;
    @(posedge ref_clk) sw_cmd <= 1'b1;
    tick(1); chk(RSPM_SOFTWARE);
    @(posedge ref_clk) begin sw_cmd <= 1'b0; reset <= 1'b1; end
    tick(2);
    checks_done++;
    if (reset_state !== 3'h0 || proc_reset_n !== 1'b0) begin
      fail_count++;
      $display("Error t=%0t state %0h exp %0h rst_n %0h exp %0h", $time, reset_state, 0,
               proc_reset_n, 0);
    end
    @(posedge ref_clk) reset <= 1'b0;
    tick(1); chk(RSPM_RUN);
    tick(1); chk(RSPM_RUN);
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    tick(2); chk(RSPM_RUN);
    s_soft_pin();
    s_wd_hold();
    s_user();
    s_rank();
    s_wake_wd();
    s_mid_reset();
    report_and_stop();
  end
endmodule
